// >>> hw/dac_host.sv
// Host end: queues 16-bit words and sends them as frames
`timescale 1ns/1ps
module dac_host
	import dac_link_pkg::*;
#(
	parameter int DIV = LINK_DIV
) (
	input  wire logic        clk,        // System clock
	input  wire logic        resetn,     // Async reset, active low
	input  wire logic        ce,         // Clock enable
	input  wire logic [15:0] word_data,  // Frame to send
	input  wire logic        word_valid, // Frame offered
	output logic             word_ready, // Queue has room
	output logic             busy_r,     // Frame in progress
	dac_link_if.host         link        // Link pins
);
	typedef enum logic [3:0] {
		H_IDLE = 4'h1, H_HIGH = 4'h2, H_LOW = 4'h4, H_GAP = 4'h8
	} hstate_e;

	hstate_e     st_r;
	logic [15:0] sh_r;
	logic [4:0]  bit_r;
	logic [$clog2(DIV+SELECT_HIGH_CYC)+1:0] tick_r;
	logic        sync_n_r;
	logic        sclk_r;
	logic        din_r;
	logic [15:0] q_data;
	logic        q_valid;
	logic        q_take;

	word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.resetn   (resetn),
		.ce       (ce),
		.in_data  (word_data),
		.in_valid (word_valid),
		.in_ready (word_ready),
		.out_data (q_data),
		.out_valid(q_valid),
		.out_ready(q_take)
	);

	assign q_take      = (st_r == H_IDLE) && q_valid;
	assign link.sync_n = sync_n_r;
	assign link.sclk   = sclk_r;
	assign link.din    = din_r;

	// Frame sequencer: clock divided down from clk
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r     <= H_IDLE;
			sh_r     <= '0;
			bit_r    <= '0;
			tick_r   <= '0;
			sync_n_r <= 1'b0;  // Idle low saves device current
			sclk_r   <= 1'b0;
			din_r    <= 1'b0;
			busy_r   <= 1'b0;
		end else if (ce) begin
			unique case (st_r)
				H_IDLE: begin
					if (q_valid) begin
						sh_r     <= q_data;
						sync_n_r <= 1'b1;  // Raise before falling
						sclk_r   <= 1'b1;
						tick_r   <= '0;
						busy_r   <= 1'b1;
						st_r     <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (tick_r == ($bits(tick_r))'(SELECT_HIGH_CYC + DIV)) begin
						sync_n_r <= 1'b0;  // Falling select opens
						din_r    <= sh_r[15];  // MSB first
						sh_r     <= {sh_r[14:0], 1'b0};
						bit_r    <= '0;
						tick_r   <= '0;
						st_r     <= H_LOW;
					end else begin
						tick_r <= tick_r + 1'b1;
					end
				end
				H_LOW: begin
					if (tick_r == ($bits(tick_r))'(DIV - 1)) begin
						tick_r <= '0;
						if (sclk_r) begin
							sclk_r <= 1'b0;
							bit_r  <= bit_r + 1'b1;  // Falling edge samples
						end else if (bit_r == 5'(FRAME_BITS)) begin
							// No rise after the last fall
							st_r <= H_GAP;
						end else begin
							sclk_r <= 1'b1;
							din_r  <= sh_r[15];
							sh_r   <= {sh_r[14:0], 1'b0};
						end
					end else begin
						tick_r <= tick_r + 1'b1;
					end
				end
				H_GAP: begin
					// Clock stopped, select and data left low
					sclk_r <= 1'b0;
					din_r  <= 1'b0;
					busy_r <= 1'b0;
					st_r   <= H_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> hw/dac_link_pkg.sv
// Shared constants and types for the serial converter write link
package dac_link_pkg;
	localparam int FRAME_BITS    = 16;
	localparam int CODE_BITS     = 10;
	localparam int MODE_HI_POS   = 13;
	localparam int MODE_LO_POS   = 12;
	localparam int CODE_LSB_POS  = 2;
	localparam int FIFO_DEPTH    = 8;
	localparam int LINK_DIV      = 4;
	localparam int SELECT_HIGH_NS = 100;
	localparam int CLK_NS        = 50;
	localparam int SELECT_HIGH_CYC =
		(SELECT_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] CODE_RESET = 10'h000;
	localparam logic [1:0] MODE_RESET = 2'h0;

	typedef enum logic [1:0] {
		MODE_NORMAL   = 2'h0,
		MODE_PD_1K    = 2'h1,
		MODE_PD_100K  = 2'h2,
		MODE_PD_HIZ   = 2'h3
	} op_mode_e;
endpackage

// >>> hw/dac_link_if.sv
// Three-wire write link between host and converter
`timescale 1ns/1ps
interface dac_link_if;
	logic sync_n;  // Frame select, active low
	logic sclk;    // Serial clock
	logic din;     // Serial data

	modport host (output sync_n, output sclk, output din);
	modport device (input sync_n, input sclk, input din);
endinterface

// >>> hw/word_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo
	import dac_link_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,      // System clock
	input  wire logic             resetn,   // Async reset, active low
	input  wire logic             ce,       // Clock enable
	input  wire logic [WIDTH-1:0] in_data,  // Write word
	input  wire logic             in_valid, // Write request
	output logic                  in_ready, // Not full
	output logic      [WIDTH-1:0] out_data, // Head word
	output logic                  out_valid,// Not empty
	input  wire logic             out_ready // Reader takes head
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	// Handshake decode
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];

	// Storage writes
	always_ff @(posedge clk) begin
		if (ce && push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// >>> hw/dac_device.sv
// Device end: serial frame receiver, code and mode registers
`timescale 1ns/1ps
module dac_device
	import dac_link_pkg::*;
#(
	parameter int CODE_W = CODE_BITS
) (
	input  wire logic        clk,       // System clock
	input  wire logic        resetn,    // Async reset, active low
	input  wire logic        ce,        // Clock enable
	dac_link_if.device       link,      // Link pins
	output logic [CODE_W-1:0] code_r,   // Converter code, ref*code/1024
	output op_mode_e          mode_r,   // Operating mode
	output logic              powered_down_r, // Analog shut down
	output logic              update_r  // Pulse on executed frame
);
	logic [1:0]  sync_s_r;
	logic [1:0]  sclk_s_r;
	logic [1:0]  din_s_r;
	logic        sync_d_r;
	logic        sclk_d_r;
	logic [15:0] sh_r;
	logic [4:0]  cnt_r;
	logic        armed_r;
	logic        sync_fall;
	logic        sync_high;
	logic        sclk_fall;

	// Two-stage synchronisers for the link pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// Reset to the idle-low level so no false fall follows reset
			sync_s_r <= 2'h0;
			sclk_s_r <= 2'h0;
			din_s_r  <= 2'h0;
			sync_d_r <= 1'b0;
			sclk_d_r <= 1'b0;
		end else if (ce) begin
			sync_s_r <= {sync_s_r[0], link.sync_n};
			sclk_s_r <= {sclk_s_r[0], link.sclk};
			din_s_r  <= {din_s_r[0], link.din};
			sync_d_r <= sync_s_r[1];
			sclk_d_r <= sclk_s_r[1];
		end
	end

	assign sync_fall = sync_d_r && !sync_s_r[1];
	assign sync_high = sync_s_r[1];
	assign sclk_fall = sclk_d_r && !sclk_s_r[1];

	// Frame shifter and bit counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sh_r    <= '0;
			cnt_r   <= '0;
			armed_r <= 1'b0;
		end else if (ce) begin
			if (sync_high) begin
				sh_r    <= '0;  // Early rise drops frame
				cnt_r   <= '0;
				armed_r <= 1'b0;
			end else if (sync_fall) begin
				armed_r <= 1'b1;  // New frame only on fall
				cnt_r   <= '0;
				sh_r    <= '0;
			end else if (armed_r && sclk_fall) begin
				sh_r  <= {sh_r[14:0], din_s_r[1]};
				cnt_r <= cnt_r + 1'b1;
				if (cnt_r == 5'(FRAME_BITS - 1)) begin
					armed_r <= 1'b0;  // Later edges ignored
				end
			end
		end
	end

	// Code and mode update on the sixteenth falling edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			code_r         <= CODE_RESET;  // Zero at power-up
			mode_r         <= MODE_NORMAL;
			powered_down_r <= 1'b0;
			update_r       <= 1'b0;
		end else if (ce) begin
			update_r <= 1'b0;
			if (!sync_high && armed_r && sclk_fall &&
			    cnt_r == 5'(FRAME_BITS - 1)) begin
				// Bit 15 and 14 dropped, mode then code
				mode_r <= op_mode_e'({sh_r[MODE_HI_POS-1],
				                      sh_r[MODE_LO_POS-1]});
				powered_down_r <= (sh_r[MODE_HI_POS-1:MODE_LO_POS-1]
				                   != 2'h0);
				// Code kept in any mode
				code_r   <= sh_r[CODE_LSB_POS+CODE_W-2:CODE_LSB_POS-1];
				update_r <= 1'b1;
			end
		end
	end
endmodule

// >>> test/dac_link_monitor.sv
// Wire checks for the three-wire converter link
`timescale 1ns/1ps
module dac_link_monitor (
	input wire logic clk,    // Clock
	input wire logic resetn, // Reset
	input wire logic sync_n, // Select
	input wire logic sclk,   // Link clock
	input wire logic din     // Data
);
	logic [4:0] nf_r; // Falls in frame
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Count link clock falls while selected
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			nf_r <= 5'h00;
		else if (sync_n)
			nf_r <= 5'h00;
		else if ($fell(sclk))
			nf_r <= nf_r + 5'h01;
	end
	property p_sel_high; $rose(sync_n) |-> sync_n[*2]; endproperty
	property p_frame; $fell(sync_n) |-> !sync_n[*8]; endproperty
	property p_max16; $fell(sclk) && !sync_n |-> nf_r < 5'h10; endproperty
	property p_low; $fell(sclk) |-> !sclk[*4]; endproperty
	property p_high; $rose(sclk) && !sync_n |-> sclk[*4]; endproperty
	property p_idle;
		nf_r == 5'h10 && !sync_n |-> ##6 (sync_n || (!sclk && !din));
	endproperty
	a_sel_high: assert property (p_sel_high)
		else $error("select high too short");
	a_frame: assert property (p_frame)
		else $error("frame cut short");
	a_max16: assert property (p_max16)
		else $error("more than sixteen falls");
	a_low: assert property (p_low)
		else $error("clock low phase short");
	a_high: assert property (p_high)
		else $error("clock high phase short");
	a_idle: assert property (p_idle)
		else $error("link not idled low");
	c_full: cover property (nf_r == 5'h10);
	c_start: cover property ($fell(sync_n));
	c_end: cover property ($rose(sync_n));
endmodule

// >>> test/serial_dac_write_control_tb.sv
// Bench for both ends of the converter link
`timescale 1ns/1ps
module serial_dac_write_control_tb;
	import dac_link_pkg::*;
	logic clk, resetn, ce, wv, wr, bz, pc, up, pc2, up2, ls, full;
	logic [15:0] wd, sh;
	logic [9:0] code, code2;
	op_mode_e mode, mode2;
	int n_mismatch = 0, checks = 0, u1 = 0, u2 = 0, i, k;
	logic [27:0] rows [6] = '{{16'hcfff, 2'h0, 10'h3ff},
		{16'h1ffc, 2'h1, 10'h3ff}, {16'h2ffc, 2'h2, 10'h3ff},
		{16'h3ffc, 2'h3, 10'h3ff}, {16'h0ffc, 2'h0, 10'h3ff},
		{16'h0aa9, 2'h0, 10'h2aa}};
	dac_link_if lk();
	dac_link_if lk2();
	dac_host dac_host_i (.clk, .resetn, .ce, .word_data(wd),
		.word_valid(wv), .word_ready(wr), .busy_r(bz), .link(lk.host));
	dac_device dac_device_i (.clk, .resetn, .ce, .link(lk.device),
		.code_r(code), .mode_r(mode), .powered_down_r(pc), .update_r(up));
	dac_device dac_device_i2 (.clk, .resetn, .ce, .link(lk2.device),
		.code_r(code2), .mode_r(mode2), .powered_down_r(pc2),
		.update_r(up2));
	dac_link_monitor dac_link_monitor_i (.clk, .resetn,
		.sync_n(lk.sync_n), .sclk(lk.sclk), .din(lk.din));
	// Clock
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// Count updates and capture bits seen on the wire
	always @(posedge clk) begin
		if (up === 1'b1) u1 <= u1 + 1;
		if (up2 === 1'b1) u2 <= u2 + 1;
		if (!lk.sync_n && ls && !lk.sclk) sh <= {sh[14:0], lk.din};
		ls <= lk.sclk;
	end
	task summarize;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task fail(input string s);
		n_mismatch++;
		$display("Error %0t: %s", $time, s);
	endtask
	task chk(input logic [15:0] g, e);
		checks++;
		if (g !== e) fail($sformatf("got %h want %h", g, e));
	endtask
	task chf(input logic g, e);
		checks++;
		if (g !== e) fail("flag wrong");
	endtask
	task wt(input int n);
		for (k = 0; k < 4000 && u1 < n; k++) @(posedge clk);
		if (u1 < n) begin
			fail("timeout");
			summarize;
		end
	endtask
	// Offer a word and hold it until the queue takes it
	task put(input logic [15:0] w);
		wd <= w;
		wv <= 1;
		for (k = 0; k < 4000; k++) begin
			@(negedge clk);
			if (wr) break;
			full = 1;
			@(posedge clk);
		end
		@(posedge clk);
		if (k == 4000) begin
			fail("timeout");
			summarize;
		end
	endtask
	// Drive a frame of n falls to the second device
	task frm(input logic [15:0] w, input int n, input logic hi);
		int j;
		@(posedge clk);
		lk2.sync_n <= 1;
		repeat (4) @(posedge clk);
		lk2.sync_n <= 0;
		for (j = 0; j < n; j++) begin
			lk2.din <= w[15 - j % 16];
			lk2.sclk <= 1;
			repeat (4) @(posedge clk);
			lk2.sclk <= 0;
			repeat (4) @(posedge clk);
		end
		lk2.sync_n <= hi;
		lk2.din <= 0;
		repeat (8) @(posedge clk);
	endtask
	initial begin
		resetn = 0; ce = 1; wv = 0; wd = 0; full = 0; ls = 0; sh = 0;
		lk2.sync_n = 0; lk2.sclk = 0; lk2.din = 0;
		repeat (16) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		chk(code, 0);
		chf(pc, 0);
		for (i = 0; i < 6; i++) begin
			put(rows[i][27:12]);
			wv <= 0;
			wt(i + 1);
			chk(sh, rows[i][27:12]);
			chk(code, rows[i][9:0]);
			chk(mode, rows[i][11:10]);
			chf(pc, rows[i][11:10] != 0);
			$display("row %0d done", i);
		end
		for (i = 0; i < 12; i++) put({4'hc, 10'(i), 2'h3});
		wv <= 0;
		wt(18);
		chk(code, 11);
		chf(full, 1);
		repeat (20) @(posedge clk);
		chf(bz, 0);
		chf(wr, 1);
		$display("fill done");
		frm(16'h0ffc, 16, 1);
		chk(u2, 1);
		frm(16'h1554, 10, 1);
		chk(u2, 1);
		chk(code2, 10'h3ff);
		chk(mode2, 0);
		frm(16'h2aa8, 20, 0);
		chk(u2, 2);
		chk(code2, 10'h2aa);
		chk(mode2, 2);
		chf(pc2, 1);
		$display("fault done");
		resetn <= 0;
		repeat (2) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		chk(code2, 0);
		chk(mode2, 0);
		$display("reset done");
		summarize;
	end
endmodule
